// >>> design/iwd_pkg.sv
/*
  Package for the I/O port watchdog: port addresses, action codes,
  prescaler figures and the carrier struct for port reads and writes.
  Assumes a 50 MHz system clock and a byte-wide I/O write strobe.
*/
// Functional notes
// - A byte written at the interval port sets a countdown of that many seconds.
// - The byte at the action port picks reset, interrupt line 10, 15 or 11, or NMI.
// - Writing zero to the interval port stops the watchdog until a nonzero load.
// - Any access to the interval port reloads the counter, which then counts down.
// - On expiry without refresh the selected reset or interrupt is raised.
package iwd_pkg;

  // ----------------------------------------------------------------
  // port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] IWD_INTERVAL_PORT = 16'h0443;
  localparam logic [15:0] IWD_ACTION_PORT   = 16'h0444;

  // ----------------------------------------------------------------
  // reset values and action codes
  // ----------------------------------------------------------------
  localparam logic [7:0] IWD_INTERVAL_RST = 8'h00;
  localparam logic [7:0] IWD_ACTION_RST   = 8'h00;

  typedef enum logic [2:0] {
    IWD_ACT_RESET = 3'b000,
    IWD_ACT_IRQ10 = 3'b001,
    IWD_ACT_IRQ15 = 3'b010,
    IWD_ACT_IRQ11 = 3'b011,
    IWD_ACT_NMI   = 3'b100
  } iwd_action_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int IWD_CLK_HZ      = 50_000_000;
  localparam int IWD_TICK_S      = 1;
  localparam int IWD_TICK_CYCLES = IWD_CLK_HZ * IWD_TICK_S;

  // ----------------------------------------------------------------
  // carrier for one I/O port access
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } iwd_io_t;

endpackage : iwd_pkg

// >>> design/iwd_watchdog.sv
/*
  I/O port watchdog timer: two write-only byte ports set the interval in
  seconds and the expiry action; expiry raises a reset or interrupt.
  Assumes I/O strobes are one-cycle pulses synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module iwd_watchdog
  import iwd_pkg::*;
#(
  parameter int TICK_CYCLES = IWD_TICK_CYCLES
) (
  // clock and reset
  input  wire logic    clk_i,
  input  wire logic    reset_i,
  // host I/O port access
  input  wire iwd_io_t io_i,
  // expiry outputs, one-cycle pulses
  output logic         sys_reset_o,
  output logic         irq10_o,
  output logic         irq15_o,
  output logic         irq11_o,
  output logic         nmi_o,
  // status
  output logic         running_o
);

  // ----------------------------------------------------------------
  // countdown states
  // ----------------------------------------------------------------
  // the timer is either stopped or counting; expiry drops back to idle
  typedef enum logic [1:0] {
    IWD_ST_IDLE  = 2'b00,
    IWD_ST_COUNT = 2'b01
  } iwd_state_t;

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  wire logic        port_access;
  wire logic        interval_sel;
  wire logic        action_sel;
  wire logic        interval_hit;
  wire logic        interval_wr;
  wire logic        action_wr;
  wire logic        action_legal;

  assign port_access  = io_i.wr | io_i.rd;
  assign interval_sel = (io_i.addr == IWD_INTERVAL_PORT);
  assign action_sel   = (io_i.addr == IWD_ACTION_PORT);
  assign interval_hit = port_access && interval_sel;
  assign interval_wr  = io_i.wr && interval_sel;
  assign action_wr    = io_i.wr && action_sel;
  // codes 5 to 7 fit the field but name no action
  assign action_legal = (io_i.data <= 8'h04);

  // ----------------------------------------------------------------
  // countdown terms
  // ----------------------------------------------------------------
  wire logic        tick;
  wire logic        last_second;
  wire logic        expire;
  wire logic        enabled;
  wire logic [7:0]  reload_value;

  logic [31:0]      prescale;
  logic [31:0]      next_prescale;
  logic [7:0]       timeout_interval_seconds;
  logic [7:0]       next_interval;
  logic [7:0]       count;
  logic [7:0]       next_count;
  iwd_state_t       state;
  iwd_state_t       next_state;
  iwd_action_t      expiry_action_select;
  iwd_action_t      next_action;

  // a write brings its own byte; a read reuses the stored one
  assign reload_value = interval_wr ? io_i.data : timeout_interval_seconds;
  assign enabled      = (state == IWD_ST_COUNT);
  // comparing with TICK_CYCLES - 1 makes each second exactly
  // TICK_CYCLES clocks long, counted from the reload
  assign tick         = (prescale == 32'(TICK_CYCLES - 1));
  // count of 1 at a tick means the interval has fully elapsed
  assign last_second  = (count == 8'h01);
  // an access in the same cycle wins, so a late refresh still saves
  assign expire       = enabled && tick && last_second && !interval_hit;

  // ----------------------------------------------------------------
  // configuration ports
  // ----------------------------------------------------------------
  always_comb begin
    next_interval = timeout_interval_seconds;
    next_action   = expiry_action_select;
    if (interval_wr) begin
      next_interval = io_i.data;
    end
    // codes above 4 are ignored; the previous action is kept
    if (action_wr && action_legal) begin
      next_action = iwd_action_t'(io_i.data[2:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timeout_interval_seconds <= IWD_INTERVAL_RST;
      expiry_action_select     <= iwd_action_t'(IWD_ACTION_RST[2:0]);
    end else begin
      timeout_interval_seconds <= next_interval;
      expiry_action_select     <= next_action;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // prescaler restarts on reload so the first second is whole
  always_comb begin
    next_prescale = prescale + 32'h0000_0001;
    if (interval_hit || !enabled || tick) begin
      next_prescale = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prescale <= 32'h0000_0000;
    end else begin
      prescale <= next_prescale;
    end
  end

  // ----------------------------------------------------------------
  // countdown control
  // ----------------------------------------------------------------
  // any access refreshes a running timer too, though the host is meant
  // to stop it first; refusing the access would only lose a refresh
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      IWD_ST_IDLE: begin
        if (interval_hit && reload_value != 8'h00) begin
          next_state = IWD_ST_COUNT;
          next_count = reload_value;
        end else if (interval_hit) begin
          next_count = 8'h00;
        end
      end
      IWD_ST_COUNT: begin
        if (interval_hit && reload_value == 8'h00) begin
          next_state = IWD_ST_IDLE;
          next_count = 8'h00;
        end else if (interval_hit) begin
          next_count = reload_value;
        end else if (expire) begin
          next_state = IWD_ST_IDLE;
          next_count = 8'h00;
        end else if (tick) begin
          next_count = count - 8'h01;
        end
      end
      default: begin
        next_state = IWD_ST_IDLE;
        next_count = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= IWD_ST_IDLE;
      count <= 8'h00;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // expiry action
  // ----------------------------------------------------------------
  wire logic [4:0]  action_onehot;
  wire logic [4:0]  action_pulse;

  // one decoded line per code, so two outputs can never pulse at once
  genvar act;
  generate
    for (act = 0; act < 5; act++) begin : g_action
      logic pulse;
      assign action_onehot[act] = (expiry_action_select == 3'(act));
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          pulse <= 1'b0;
        end else begin
          pulse <= expire && action_onehot[act];
        end
      end
      assign action_pulse[act] = pulse;
    end
  endgenerate

  // ----------------------------------------------------------------
  // status and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      running_o <= 1'b0;
    end else begin
      running_o <= enabled;
    end
  end

  // outputs stay one flop deep; the mapping below is wiring only
  assign sys_reset_o = action_pulse[IWD_ACT_RESET];
  assign irq10_o     = action_pulse[IWD_ACT_IRQ10];
  assign irq15_o     = action_pulse[IWD_ACT_IRQ15];
  assign irq11_o     = action_pulse[IWD_ACT_IRQ11];
  assign nmi_o       = action_pulse[IWD_ACT_NMI];

endmodule : iwd_watchdog
`default_nettype wire

// >>> tb/iwd_host.sv
/* host model: byte writes to the I/O ports, one-cycle strobes */
`timescale 1ns/1ps
`default_nettype none
module iwd_host
  import iwd_pkg::*;
(
  input  wire logic clk_i,
  output var iwd_io_t io_o
);
  initial io_o = '0;
  // zero before reload is left to the caller
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_o = '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    io_o = '{1'b0, 1'b0, ~a, ~d};
  endtask : put
  // read access; the watchdog only cares that the port was touched
  task automatic get(input logic [15:0] a);
    @(negedge clk_i);
    io_o = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    io_o = '{1'b0, 1'b0, ~a, 8'hff};
  endtask : get
endmodule : iwd_host
`default_nettype wire

// >>> tb/iwd_watchdog_sva.sv
/* checks on the watchdog ports; bound to iwd_watchdog */
`timescale 1ns/1ps
`default_nettype none
module iwd_watchdog_sva
  import iwd_pkg::*;
#(parameter int TICK_CYCLES = 4)
(
  input wire logic    clk_i,
  input wire logic    reset_i,
  input wire iwd_io_t io_i,
  input wire logic    sys_reset_o, irq10_o, irq15_o, irq11_o, nmi_o,
  input wire logic    running_o
);
  wire logic w = io_i.wr && io_i.addr == IWD_INTERVAL_PORT;
  wire logic [4:0] ev = {nmi_o, irq11_o, irq15_o, irq10_o, sys_reset_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_one; $onehot0(ev); endproperty
  a_one: assert property (p_one) else $error("two actions");
  property p_pls; ev != 5'h00 |=> ev == 5'h00; endproperty
  a_pls: assert property (p_pls) else $error("long pulse");
  property p_act; ev != 5'h00 |-> running_o; endproperty
  a_act: assert property (p_act) else $error("idle expiry");
  property p_ld; w && io_i.data != 8'h00 |-> ##2 running_o; endproperty
  a_ld: assert property (p_ld) else $error("no start");
  property p_st; w && io_i.data == 8'h00 |-> ##2 !running_o; endproperty
  a_st: assert property (p_st) else $error("no stop");
  property p_rs; disable iff (1'b0) reset_i |=> !running_o && !ev; endproperty
  a_rs: assert property (p_rs) else $error("reset");
endmodule : iwd_watchdog_sva
`default_nettype wire

// >>> tb/iwd_watchdog_test.sv
/* watchdog bench; host model drives io, watcher checks pulses */
`timescale 1ns/1ps
`default_nettype none
module iwd_watchdog_test;
  import iwd_pkg::*;
  localparam int T = 4;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  iwd_io_t io;
  wire logic [4:0] ev;
  wire logic run;
  logic [4:0] exp_q[$];
  int err_total = 0, cmp_count = 0;
  always #10 clk_i = ~clk_i;
  iwd_host iwd_host_inst (.clk_i(clk_i), .io_o(io));
  iwd_watchdog #(.TICK_CYCLES(T)) iwd_watchdog_inst (.clk_i(clk_i),
    .reset_i(reset_i), .io_i(io), .sys_reset_o(ev[0]), .irq10_o(ev[1]),
    .irq15_o(ev[2]), .irq11_o(ev[3]), .nmi_o(ev[4]), .running_o(run));
  task automatic chk(input logic [4:0] s, input logic [4:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic final_report();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  always @(negedge clk_i) if (!reset_i && ev !== 5'h00) begin
    if (exp_q.size() == 0) chk(ev, 5'h00);
    else chk(ev, exp_q.pop_front());
  end
  task automatic wait_pulse(input int lim);
    for (int i = 0; i < lim && exp_q.size() != 0; i++) @(negedge clk_i);
    chk(5'(exp_q.size()), 5'h00);
    if (exp_q.size() != 0) final_report();
    repeat (2) @(negedge clk_i);
    chk({4'h0, run}, 5'h00);
  endtask : wait_pulse
  task automatic arm(input logic [7:0] a, n, input logic [4:0] e);
    exp_q.push_back(e);
    iwd_host_inst.put(IWD_ACTION_PORT, a);
    iwd_host_inst.put(IWD_INTERVAL_PORT, n);
    @(negedge clk_i);
    chk({4'h0, run}, 5'h01);
    wait_pulse(n * T + 8);
  endtask : arm
  initial begin
    logic [7:0] n;
    n = 8'($urandom(32'haa627472));
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    for (int k = 0; k < 5; k++) begin
      n = 8'($urandom_range(2, 6));
      arm(8'(k), n, 5'h01 << k);
    end
    // code 5 is refused, nmi stays selected
    arm(8'h05, 8'h02, 5'h10);
    iwd_host_inst.put(IWD_INTERVAL_PORT, 8'h03);
    iwd_host_inst.put(IWD_INTERVAL_PORT, 8'h00);
    repeat (40) @(negedge clk_i);
    chk({4'h0, run}, 5'h00);
    // refresh in the host's order: stop with zero, then reload
    exp_q.push_back(5'h02);
    iwd_host_inst.put(IWD_ACTION_PORT, 8'h01);
    iwd_host_inst.put(IWD_INTERVAL_PORT, 8'h03);
    repeat (8) @(negedge clk_i);
    iwd_host_inst.put(IWD_INTERVAL_PORT, 8'h00);
    iwd_host_inst.put(IWD_INTERVAL_PORT, 8'h03);
    repeat (8) @(negedge clk_i);
    chk(5'(exp_q.size()), 5'h01);
    wait_pulse(40);
    // after expiry a read of the interval port starts it again
    exp_q.push_back(5'h02);
    iwd_host_inst.get(IWD_INTERVAL_PORT);
    wait_pulse(40);
    arm(8'h02, 8'hff, 5'h04);
    final_report();
  end
endmodule : iwd_watchdog_test
bind iwd_watchdog iwd_watchdog_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_inst (.*);
`default_nettype wire
